// File: pkg/tcc_params.svh
// Offsets, field positions, reset values and mode codes of the timer
// channel. Assumes inclusion by bare name from the design files.
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
// Register offsets on the plain register port
`define TCC_OFS_CNT_HI   4'h0
`define TCC_OFS_CNT_LO   4'h1
`define TCC_OFS_RLD_HI   4'h2
`define TCC_OFS_RLD_LO   4'h3
`define TCC_OFS_CAP_HI   4'h4
`define TCC_OFS_CAP_LO   4'h5
`define TCC_OFS_CTL0     4'h6
`define TCC_OFS_CTL1     4'h7
`define TCC_OFS_OUTCTL   4'h8
// Field positions in timer_control_zero
`define TCC_C0_MODEH     7
`define TCC_C0_ISRC_HI   6
`define TCC_C0_ISRC_LO   5
`define TCC_C0_CAPF      0
// Field positions in timer_control_one
`define TCC_C1_EN        7
`define TCC_C1_POL       6
`define TCC_C1_PRE_HI    5
`define TCC_C1_PRE_LO    3
`define TCC_C1_MODE_HI   2
`define TCC_C1_MODE_LO   0
// Field position in the output control register
`define TCC_OC_ALT_EN    0
// Mode codes {mode_select_high, mode_select_low}
`define TCC_MODE_CAPRST  4'h6
`define TCC_MODE_COMPARE 4'h2
`define TCC_MODE_GATED   4'h5
`define TCC_MODE_CAPCMP  4'h7
// Reset and restart values, interrupt source codes
`define TCC_CNT_RESET    16'h0001
`define TCC_CNT_RESTART  16'h0001
`define TCC_RLD_RESET    16'hFFFF
`define TCC_CAP_RESET    16'h0000
`define TCC_ISRC_INPUT   2'h2
`define TCC_ISRC_RELOAD  2'h3
`endif

// File: pkg/tcc_pkg.sv
// Types shared by the timer channel.
// Assumes the offsets and codes come from tcc_params.svh.
package tcc_pkg;
   // Operating mode as decoded from the mode fields
   typedef enum logic [2:0] {
      tcc_mode_off,
      tcc_mode_caprst,
      tcc_mode_compare,
      tcc_mode_gated,
      tcc_mode_capcmp
   } tcc_mode_t;
   // Configuration written by software
   typedef struct packed {
      logic       enable;
      logic       polarity;
      logic [2:0] prescale;
      logic [3:0] mode_code;
      logic [1:0] irq_src;
      logic       out_alt_en;
   } tcc_cfg_t;
endpackage

// File: logic/tcc_timer.sv
// 16-bit timer channel: capture-restart, compare, gated, capture/compare.
// Assumes one clock, software at the plain register port, and an
// asynchronous timer input pin.
`timescale 1ns/1ps
`include "tcc_params.svh"

module tcc_timer #(
   parameter int PRE_W = 7
) (
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   input  wire logic       timer_pin_in,
   output logic            timer_pin_out,
   output logic            timer_irq_out,
   output logic            capture_cause_flag_out
);

   // Prescale terminal count for a divide by two to the power p
   function automatic logic [PRE_W-1:0] tcc_pre_limit(input logic [2:0] p);
      tcc_pre_limit = PRE_W'((8'h01 << p) - 8'h01);
   endfunction

   // Decode of the mode fields
   function automatic tcc_pkg::tcc_mode_t tcc_decode(input logic [3:0] c);
      case (c)
         `TCC_MODE_CAPRST:  tcc_decode = tcc_pkg::tcc_mode_caprst;
         `TCC_MODE_COMPARE: tcc_decode = tcc_pkg::tcc_mode_compare;
         `TCC_MODE_GATED:   tcc_decode = tcc_pkg::tcc_mode_gated;
         `TCC_MODE_CAPCMP:  tcc_decode = tcc_pkg::tcc_mode_capcmp;
         default:           tcc_decode = tcc_pkg::tcc_mode_off;
      endcase
   endfunction

   tcc_pkg::tcc_cfg_t  cfg_r;
   tcc_pkg::tcc_mode_t mode;
   logic [15:0]        cnt_r;
   logic [15:0]        cnt_nxt;
   logic [15:0]        rld_r;
   logic [15:0]        cap_r;
   logic [7:0]         rld_hold_r;
   logic [7:0]         rd_hold_r;
   logic [7:0]         rdata_r;
   logic [PRE_W-1:0]   pre_r;
   logic               sync1_r;
   logic               sync2_r;
   logic               sync3_r;
   logic               started_r;
   logic               capf_r;
   logic               out_r;
   logic               irq_r;
   logic               en;
   logic               active;
   logic               active_prev;
   logic               sel_edge;
   logic               run;
   logic               tick;
   logic               match;
   logic               cap_ev;
   logic               first_ev;
   logic               rld_ev;
   logic               deassert_ev;
   logic               in_ev;
   logic               irq_nxt;
   logic               restart_mode;
   logic               cnt_wr;

   assign mode = tcc_decode(cfg_r.mode_code);
   assign en   = cfg_r.enable;

   // Two-stage synchroniser plus one stage of history for edges
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else begin
         sync1_r <= timer_pin_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Edge and level decisions from the synchronised value only
   assign sel_edge    = cfg_r.polarity ? (sync3_r & ~sync2_r)
                                       : (sync2_r & ~sync3_r);
   assign active      = sync2_r ^ cfg_r.polarity;
   assign active_prev = sync3_r ^ cfg_r.polarity;

   // Counting permission per mode; the pin never clocks the counter
   always_comb begin
      case (mode)
         tcc_pkg::tcc_mode_caprst:  run = en;
         tcc_pkg::tcc_mode_compare: run = en;
         tcc_pkg::tcc_mode_gated:   run = en & active;
         tcc_pkg::tcc_mode_capcmp:  run = en & started_r;
         default:                   run = 1'b0;
      endcase
   end

   // Prescaler, restarted while the counter is held
   assign tick = run && (pre_r == tcc_pre_limit(cfg_r.prescale));
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pre_r <= '0;
      end else if (!run || tick) begin
         pre_r <= '0;
      end else begin
         pre_r <= PRE_W'(pre_r + 1'b1);
      end
   end

   // Events of the current cycle
   assign restart_mode = (mode == tcc_pkg::tcc_mode_caprst) ||
                         (mode == tcc_pkg::tcc_mode_capcmp);
   assign match    = tick && (cnt_r == rld_r);
   assign cap_ev   = en && sel_edge &&
                     ((mode == tcc_pkg::tcc_mode_caprst) ||
                      ((mode == tcc_pkg::tcc_mode_capcmp) && started_r));
   assign first_ev = en && sel_edge && !started_r &&
                     (mode == tcc_pkg::tcc_mode_capcmp);
   assign rld_ev   = match && !cap_ev;
   assign deassert_ev = en && (mode == tcc_pkg::tcc_mode_gated) &&
                        active_prev && !active;
   assign in_ev    = cap_ev || deassert_ev;
   assign cnt_wr   = wr_in && ((addr_in == `TCC_OFS_CNT_HI) ||
                               (addr_in == `TCC_OFS_CNT_LO));

   // Interrupt source filter
   assign irq_nxt = (in_ev && (cfg_r.irq_src != `TCC_ISRC_RELOAD)) ||
                    (rld_ev && (cfg_r.irq_src != `TCC_ISRC_INPUT));

   // Capture/compare start latch, cleared whenever not armed
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         started_r <= 1'b0;
      end else if (!en || (mode != tcc_pkg::tcc_mode_capcmp)) begin
         started_r <= 1'b0;
      end else if (first_ev) begin
         started_r <= 1'b1;
      end
   end

   // Next count: capture and reload restart, compare keeps counting
   always_comb begin
      cnt_nxt = cnt_r;
      if (cap_ev) begin
         cnt_nxt = `TCC_CNT_RESTART;
      end else if (rld_ev && (mode != tcc_pkg::tcc_mode_compare)) begin
         cnt_nxt = `TCC_CNT_RESTART;
      end else if (tick) begin
         cnt_nxt = cnt_r + 16'h0001;
      end
      if (wr_in && (addr_in == `TCC_OFS_CNT_HI)) begin
         cnt_nxt[15:8] = wdata_in;
      end
      if (wr_in && (addr_in == `TCC_OFS_CNT_LO)) begin
         cnt_nxt[7:0] = wdata_in;
      end
   end

   // Counter register
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_r <= `TCC_CNT_RESET;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // Reload value: high byte waits in a holding byte for the low write
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rld_hold_r <= 8'(`TCC_RLD_RESET >> 8);
         rld_r      <= `TCC_RLD_RESET;
      end else if (wr_in && (addr_in == `TCC_OFS_RLD_HI)) begin
         rld_hold_r <= wdata_in;
      end else if (wr_in && (addr_in == `TCC_OFS_RLD_LO)) begin
         rld_r <= {rld_hold_r, wdata_in};
      end
   end

   // Capture register; a capture wins over a software write
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cap_r <= `TCC_CAP_RESET;
      end else if (cap_ev) begin
         cap_r <= cnt_r;
      end else if (wr_in && (addr_in == `TCC_OFS_CAP_HI)) begin
         cap_r[15:8] <= wdata_in;
      end else if (wr_in && (addr_in == `TCC_OFS_CAP_LO)) begin
         cap_r[7:0] <= wdata_in;
      end
   end

   // Capture-cause flag, set by each capture, cleared by a reload in capture-restart or capture/compare mode
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         capf_r <= 1'b0;
      end else if (cap_ev) begin
         capf_r <= 1'b1;
      end else if (rld_ev && restart_mode) begin
         capf_r <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cfg_r <= '0;
      end else if (wr_in && (addr_in == `TCC_OFS_CTL0)) begin
         cfg_r.mode_code[3] <= wdata_in[`TCC_C0_MODEH];
         cfg_r.irq_src <= wdata_in[`TCC_C0_ISRC_HI:`TCC_C0_ISRC_LO];
      end else if (wr_in && (addr_in == `TCC_OFS_CTL1)) begin
         cfg_r.enable    <= wdata_in[`TCC_C1_EN];
         cfg_r.polarity  <= wdata_in[`TCC_C1_POL];
         cfg_r.prescale  <= wdata_in[`TCC_C1_PRE_HI:`TCC_C1_PRE_LO];
         cfg_r.mode_code[2:0] <= wdata_in[`TCC_C1_MODE_HI:`TCC_C1_MODE_LO];
      end else if (wr_in && (addr_in == `TCC_OFS_OUTCTL)) begin
         cfg_r.out_alt_en <= wdata_in[`TCC_OC_ALT_EN];
      end
   end

   // Output pin: starts at the polarity level, toggles on reload in compare and gated modes
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         out_r <= 1'b0;
      end else if (!en) begin
         out_r <= cfg_r.polarity;
      end else if (cfg_r.out_alt_en && rld_ev &&
                   ((mode == tcc_pkg::tcc_mode_compare) ||
                    (mode == tcc_pkg::tcc_mode_gated))) begin
         out_r <= ~out_r;
      end
   end

   // Interrupt pulse register
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // Read holding byte: high-byte read freezes the low byte
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_hold_r <= 8'h00;
      end else if (rd_in && en && (addr_in == `TCC_OFS_CNT_HI)) begin
         rd_hold_r <= cnt_r[7:0];
      end
   end

   // Read data, present only in the cycle after the read strobe
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_r <= 8'h00;
      end else if (!rd_in) begin
         rdata_r <= 8'h00;
      end else begin
         case (addr_in)
            `TCC_OFS_CNT_HI: rdata_r <= cnt_r[15:8];
            `TCC_OFS_CNT_LO: rdata_r <= en ? rd_hold_r : cnt_r[7:0];
            `TCC_OFS_RLD_HI: rdata_r <= rld_r[15:8];
            `TCC_OFS_RLD_LO: rdata_r <= rld_r[7:0];
            `TCC_OFS_CAP_HI: rdata_r <= cap_r[15:8];
            `TCC_OFS_CAP_LO: rdata_r <= cap_r[7:0];
            `TCC_OFS_CTL0:   rdata_r <= {cfg_r.mode_code[3], cfg_r.irq_src,
                                         4'h0, capf_r};
            `TCC_OFS_CTL1:   rdata_r <= {cfg_r.enable, cfg_r.polarity,
                                         cfg_r.prescale,
                                         cfg_r.mode_code[2:0]};
            `TCC_OFS_OUTCTL: rdata_r <= {7'h00, cfg_r.out_alt_en};
            default:         rdata_r <= 8'h00;
         endcase
      end
   end

   // Outputs
   assign rdata_out              = rdata_r;
   assign timer_pin_out          = out_r;
   assign timer_irq_out          = irq_r;
   assign capture_cause_flag_out = capf_r;

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   sequence pin_high_held;
      timer_pin_in [*3];
   endsequence

   sequence compare_hit;
      (mode == tcc_pkg::tcc_mode_compare) && match && !cnt_wr;
   endsequence

   sync_path_a: assert property (pin_high_held |-> sync2_r)
      else $error("synchroniser output lags a steady pin");

   cap_store_a: assert property (cap_ev |=> cap_r == $past(cnt_r))
      else $error("capture did not store the count");

   cap_restart_a: assert property (
         cap_ev && !cnt_wr |=> cnt_r == 16'h0001 ##1 1'b1)
      else $error("capture did not restart the count");

   cap_irq_a: assert property (
         cap_ev && cfg_r.irq_src != 2'h3 |=>
         timer_irq_out && capture_cause_flag_out)
      else $error("capture gave no interrupt or cause flag");

   reload_cause_a: assert property (
         rld_ev && restart_mode |=> !capture_cause_flag_out)
      else $error("reload left cause flag set");

   cmp_continue_a: assert property (
         compare_hit |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("compare match changed the count sequence");

   cmp_toggle_a: assert property (
         (compare_hit and cfg_r.out_alt_en) |=>
         timer_pin_out != $past(timer_pin_out))
      else $error("compare match did not toggle output");

   cmp_wrap_a: assert property (
         (mode == tcc_pkg::tcc_mode_compare) && tick &&
         cnt_r == 16'hFFFF && !cnt_wr |=> cnt_r == 16'h0000)
      else $error("counter did not wrap to zero");

   gate_hold_a: assert property (
         (mode == tcc_pkg::tcc_mode_gated) && !active && !cnt_wr |=>
         $stable(cnt_r))
      else $error("gated counter moved while inactive");

   gate_deassert_a: assert property (
         deassert_ev && cfg_r.irq_src != 2'h3 |=> timer_irq_out)
      else $error("deassertion gave no interrupt");

   gate_reload_a: assert property (
         (mode == tcc_pkg::tcc_mode_gated) && match && !cnt_wr |=>
         cnt_r == 16'h0001)
      else $error("gated reload did not load restart value");

   first_edge_a: assert property (
         first_ev |=> !timer_irq_out ##1 (started_r || !en))
      else $error("first edge interrupted or did not start");

   src_filter_a: assert property (
         cfg_r.irq_src == 2'h2 && rld_ev && !in_ev |=> !timer_irq_out)
      else $error("reload interrupt not suppressed");

endmodule

// File: verif/tcc_pin_src.sv
// Far-side source that drives the timer input pin.
// Assumes the bench asks for each level and holds it two clocks or more.
`timescale 1ns/1ps

module tcc_pin_src (
   input  wire logic clk_in,
   input  wire logic level_in,
   output logic      pin_out
);
   logic pin_r = 1'b0;

   // Pin moves just after a rising edge, as a board driver would
   always @(posedge clk_in) begin
      pin_r <= level_in;
   end
   assign pin_out = pin_r;
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the timer channel: registers and four modes.
// Assumes the design header, the design and the pin source are compiled.
`timescale 1ns/1ps
`include "tcc_params.svh"

module tb_top;
   logic        clk_in   = 1'b0;
   logic        nrst_in;
   logic [3:0]  addr_in;
   logic [7:0]  wdata_in;
   logic        wr_in;
   logic        rd_in;
   logic        pin_req;
   logic        rd_d     = 1'b0;
   logic [15:0] rs       = 16'h9F04;
   logic        timer_pin_in;
   logic [7:0]  rdata_out;
   logic        timer_pin_out;
   logic        timer_irq_out;
   logic        capture_cause_flag_out;
   logic [7:0]  rq[$];
   logic [1:0]  iq[$];
   int          fail_count = 0;
   int          cmp_count  = 0;
   localparam logic [7:0] RV [9] = '{8'h00, 8'h01, 8'hFF, 8'hFF, 8'h00,
                                     8'h00, 8'h00, 8'h00, 8'h00};

   tcc_timer #(.PRE_W(7)) tcc_timer_i (
      .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .timer_pin_in(timer_pin_in),
      .timer_pin_out(timer_pin_out), .timer_irq_out(timer_irq_out),
      .capture_cause_flag_out(capture_cause_flag_out));
   tcc_pin_src tcc_pin_src_i (
      .clk_in(clk_in), .level_in(pin_req), .pin_out(timer_pin_in));

   // 250 MHz clock
   always #2 clk_in = ~clk_in;

   function automatic logic [15:0] xs(input logic [15:0] s);
      s = s ^ (s << 7);
      s = s ^ (s >> 9);
      return s ^ (s << 8);
   endfunction

   task automatic chk_rd(input string n, input logic [7:0] e,
                         input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic chk_bit(input string n, input logic e, input logic s);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %b seen %b", n, e, s);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // One-cycle write strobe, then a quiet cycle before the next request
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in    <= 1'b0;
   endtask

   // Read strobe; the expected byte waits in the queue for the monitor
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_in);
      rq.push_back(e);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in   <= 1'b0;
   endtask

   task automatic wr2(input logic [3:0] a, input logic [15:0] v);
      wr(a, v[15:8]);
      wr(a + 4'h1, v[7:0]);
   endtask

   task automatic rd2(input logic [3:0] a, input logic [15:0] v);
      rd(a, v[15:8]);
      rd(a + 4'h1, v[7:0]);
   endtask

   // Disable, set pin idle, program, clear capture, enable last
   task automatic cfg(input logic [7:0] c0, input logic [7:0] c1,
                      input logic [15:0] cnt, input logic [15:0] rld,
                      input logic idle);
      wr(`TCC_OFS_CTL1, c1 & 8'h7F);
      pin_req <= idle;
      wr(`TCC_OFS_CTL0, c0);
      wr2(`TCC_OFS_CNT_HI, cnt);
      wr2(`TCC_OFS_RLD_HI, rld);
      wr2(`TCC_OFS_CAP_HI, 16'h0000);
      wt(8);
      wr(`TCC_OFS_CTL1, c1);
   endtask

   task automatic end_test(input string n);
      wt(4);
      chk_bit("missing interrupt", 1'b0, iq.size() != 0);
      $display("done %s", n);
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Monitor: read data one cycle after the strobe, interrupt pulses
   always @(posedge clk_in) begin
      logic [1:0] n;
      if (rd_d) begin
         if (rq.size() == 0) chk_bit("read note", 1'b0, 1'b1);
         else chk_rd("read data", rq.pop_front(), rdata_out);
      end
      if (timer_irq_out !== 1'b0) begin
         if (iq.size() == 0) begin
            chk_bit("unexpected interrupt", 1'b0, timer_irq_out);
         end else begin
            n = iq.pop_front();
            if (n[1]) chk_bit("cause flag", n[0], capture_cause_flag_out);
         end
      end
      rd_d <= rd_in;
   end

   // Watchdog well beyond the expected five thousand cycles
   initial begin
      wt(40000);
      fail_count++;
      complete_run();
   end

   initial begin
      nrst_in  <= 1'b0;
      addr_in  <= 4'h0;
      wdata_in <= 8'h00;
      wr_in    <= 1'b0;
      rd_in    <= 1'b0;
      pin_req  <= 1'b0;
      wt(4);
      nrst_in <= 1'b1;
      for (int i = 0; i < 9; i++) rd(i[3:0], RV[i]);
      rd(4'hF, 8'h00);
      for (int i = 0; i < 3; i++) begin
         rs = xs(rs);
         wr2(`TCC_OFS_RLD_HI, rs);
         wr(4'hF, rs[7:0]);
         rd2(`TCC_OFS_RLD_HI, rs);
         rd(4'hF, 8'h00);
      end
      end_test("registers");
      // Capture-restart, rising then falling capture edge
      for (int p = 0; p < 2; p++) begin
         cfg(8'h00, {1'b1, p[0], 6'h3E}, 16'h0010, 16'hFFFF, p[0]);
         wt(448);
         iq.push_back(2'b11);
         pin_req <= ~p[0];
         wt(24);
         rd2(`TCC_OFS_CAP_HI, 16'h0013);
         rd2(`TCC_OFS_CNT_HI, 16'h0001);
         pin_req <= p[0];
         wt(40);
         rd2(`TCC_OFS_CAP_HI, 16'h0013);
      end
      end_test("capture restart");
      cfg(8'h00, 8'hBE, 16'h0001, 16'h0003, 1'b0);
      iq.push_back(2'b10);
      wt(440);
      rd2(`TCC_OFS_CAP_HI, 16'h0000);
      wr(`TCC_OFS_CTL1, 8'h3E);
      end_test("reload restart");
      // Compare with wrap, output toggle, pin ignored as a clock
      wr(`TCC_OFS_OUTCTL, 8'h01);
      cfg(8'h20, 8'hBA, 16'hFFFE, 16'h0001, 1'b0);
      chk_bit("output pin", 1'b0, timer_pin_out);
      iq.push_back(2'b00);
      pin_req <= 1'b1;
      wt(300);
      rd2(`TCC_OFS_CNT_HI, 16'h0000);
      wt(260);
      rd2(`TCC_OFS_CNT_HI, 16'h0002);
      chk_bit("output pin", 1'b1, timer_pin_out);
      end_test("compare");
      // Gated: reload inside the active phase, then deassertion
      cfg(8'h00, 8'hBD, 16'h0010, 16'h0012, 1'b0);
      iq.push_back(2'b00);
      pin_req <= 1'b1;
      wt(560);
      iq.push_back(2'b00);
      pin_req <= 1'b0;
      wt(20);
      rd2(`TCC_OFS_CNT_HI, 16'h0002);
      chk_bit("output pin", 1'b1, timer_pin_out);
      chk_bit("input level", 1'b0, timer_pin_in);
      wt(300);
      rd2(`TCC_OFS_CNT_HI, 16'h0002);
      end_test("gated");
      // Capture/compare, input events only
      cfg(8'h40, 8'hBF, 16'h0001, 16'h0002, 1'b0);
      wt(300);
      rd2(`TCC_OFS_CNT_HI, 16'h0001);
      pin_req <= 1'b1;
      wt(100);
      pin_req <= 1'b0;
      wt(348);
      iq.push_back(2'b11);
      pin_req <= 1'b1;
      wt(20);
      rd2(`TCC_OFS_CAP_HI, 16'h0002);
      rd2(`TCC_OFS_CNT_HI, 16'h0001);
      end_test("capture compare");
      // Capture/compare, compare events only: capture stays silent
      cfg(8'h60, 8'hBF, 16'h0001, 16'h0003, 1'b0);
      pin_req <= 1'b1;
      wt(192);
      pin_req <= 1'b0;
      wt(8);
      iq.push_back(2'b10);
      pin_req <= 1'b1;
      wt(450);
      wr(`TCC_OFS_CTL1, 8'h3F);
      end_test("source filter");
      complete_run();
   end
endmodule
